// file: lsl_latch_loader.sv
// Segment latch loader with display blanking and stop grounding.
// Assumes the execution unit presents one instruction per valid cycle
// and the table ROM answers TROM_DATA for TROM_ADDR in the same cycle.
//
// Contract
// (R1) Flag 4h blanks, reset restores; latches kept
// (R2) Latch loads still work while blanked
// (R3) Stop state grounds every common and segment
// (R4) Decoded load: register nibble through decoder
// (R5) Blanking load: zero nibble gives all-zero bus
// (R6) Direct load: register and accumulator nibbles raw
// (R7) Table load: table byte at index raw
// (R8) Indexed form takes nibble at index buffer
// (R9) Latch address 0..F asserts exactly one strobe
// (R10) Five latches per pin, PLA picks bus/strobe
// (R11) Pin codes only 0..5 and 9
// (R12) Working register address is operand plus 70h
// (R13) Index buffer 8 bits, high/low nibble loads
// (R14) Data memory is not cleared by reset
// (R15) Decoder table for digits, A..F all zero
// (R16) Digit seven F line fixed by option
// (R17) Direct: A..D register, E..H accumulator
// (R18) Table: lines A..H are byte bits 0..7
// (R19) Blanked outputs unlit, resume next cycle
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`default_nettype none

module lsl_latch_loader import lsl_pkg::*; #(
	parameter logic SEVEN_F_ON = 1'b0
) (
	// Clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              RST,
	// Instruction from the execution unit
	input  wire logic              INSTR_VALID,
	input  wire lsl_op_t           INSTR_OP,
	input  wire logic              INSTR_INDEXED,
	input  wire logic [3:0]        LATCH_ADDR,
	input  wire logic [3:0]        WREG_OPERAND,
	input  wire logic [3:0]        FLAG_OPERAND,
	input  wire logic [6:0]        DATA_ADDR,
	input  wire logic [3:0]        ACCUMULATOR,
	input  wire logic              CORE_STOP,
	// Data memory write port
	input  wire logic              MEM_WE,
	input  wire logic [6:0]        MEM_WADDR,
	input  wire logic [3:0]        MEM_WDATA,
	// Table ROM
	output logic [7:0]             TROM_ADDR,
	input  wire logic [7:0]        TROM_DATA,
	// Panel and DC outputs
	output logic [NUM_LATCH-1:0]   SEG_PATTERN,
	output logic                   PANEL_GROUND,
	output logic                   PANEL_BLANK,
	output logic [NUM_SEG-1:0]     DC_OUT,
	output logic [NUM_SEG-1:0]     DC_OE_N,
	// AXI4-Lite slave
	input  wire logic [3:0]        AXI_AWADDR,
	input  wire logic              AXI_AWVALID,
	output logic                   AXI_AWREADY,
	input  wire logic [31:0]       AXI_WDATA,
	input  wire logic [3:0]        AXI_WSTRB,
	input  wire logic              AXI_WVALID,
	output logic                   AXI_WREADY,
	output logic [1:0]             AXI_BRESP,
	output logic                   AXI_BVALID,
	input  wire logic              AXI_BREADY,
	input  wire logic [3:0]        AXI_ARADDR,
	input  wire logic              AXI_ARVALID,
	output logic                   AXI_ARREADY,
	output logic [31:0]            AXI_RDATA,
	output logic [1:0]             AXI_RRESP,
	output logic                   AXI_RVALID,
	input  wire logic              AXI_RREADY
);

	// ----------------------------------------------------------------
	// Data memory and index buffer
	// ----------------------------------------------------------------
	logic [3:0]           mem_r [MEM_DEPTH];
	logic [7:0]           index_r;
	logic [7:0]           index_nxt;
	logic [6:0]           src_addr;
	logic [3:0]           src_nib;
	logic [3:0]           data_nib;

	// No reset on purpose: software initialises it before use
	always_ff @(posedge REF_CLK) begin
		if (MEM_WE)
			mem_r[MEM_WADDR] <= MEM_WDATA; // see (R14)
	end

	// Source nibble from working register or indexed location
	assign src_addr = INSTR_INDEXED ? index_r[6:0] : // see (R8)
		{3'b000, WREG_OPERAND} + WREG_BASE;      // see (R12)
	assign src_nib  = mem_r[src_addr];
	assign data_nib = mem_r[DATA_ADDR];

	// Nibble loads of the index buffer
	assign index_nxt =
		(INSTR_VALID && INSTR_OP == OP_INDEX_HIGH) ?
			{data_nib, index_r[3:0]} :                // see (R13)
		(INSTR_VALID && INSTR_OP == OP_INDEX_LOW) ?
			{index_r[7:4], data_nib} : index_r;       // see (R13)

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			index_r <= INDEX_RST;
		else
			index_r <= index_nxt;
	end

	assign TROM_ADDR = index_r;

	// ----------------------------------------------------------------
	// Bus line selection and strobe decode
	// ----------------------------------------------------------------
	logic [7:0]           dec_bus;
	logic [7:0]           seg_bus;
	logic                 load;
	logic [NUM_STB-1:0]   strobe;

	assign dec_bus = seg7_decode(src_nib, SEVEN_F_ON); // see (R15) (R16)
	assign load = INSTR_VALID && (INSTR_OP == OP_DECODED ||
		INSTR_OP == OP_BLANKING || INSTR_OP == OP_DIRECT ||
		INSTR_OP == OP_TABLE);

	// Bus lines per instruction; bit 0 is line A
	assign seg_bus =
		(INSTR_OP == OP_DECODED) ? dec_bus :            // see (R4)
		(INSTR_OP == OP_BLANKING) ?
			((src_nib == ZERO_NIB) ? BUS_ZERO : dec_bus) : // see (R5)
		(INSTR_OP == OP_DIRECT) ? {ACCUMULATOR, src_nib} : // see (R6) (R17)
		(INSTR_OP == OP_TABLE) ? TROM_DATA : BUS_ZERO;  // see (R7) (R18)

	// One strobe per latch address, only during a load
	assign strobe = load ? (16'h0001 << LATCH_ADDR) : 16'h0000; // see (R9)

	// ----------------------------------------------------------------
	// Display flags
	// ----------------------------------------------------------------
	logic                 disp_off_r;
	logic                 disp_off_nxt;
	logic                 ctrl_blank_r;
	logic                 blank;
	logic                 flag_op;

	assign flag_op = INSTR_VALID && FLAG_OPERAND == BLANK_FLAG &&
		(INSTR_OP == OP_SET_FLAG2 || INSTR_OP == OP_RESET_FLAG2);
	// Latches are not touched here, so the old pattern returns
	assign disp_off_nxt = flag_op ? (INSTR_OP == OP_SET_FLAG2) :
		disp_off_r;                                   // see (R1)
	assign blank = disp_off_r | ctrl_blank_r;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			disp_off_r <= 1'b0;
		else
			disp_off_r <= disp_off_nxt;
	end

	// ----------------------------------------------------------------
	// Segment latches and outputs
	// ----------------------------------------------------------------
	logic [NUM_LATCH-1:0] latch_r;
	logic [NUM_LATCH-1:0] lcd_mask;

	genvar i;
	generate
		for (i = 0; i < NUM_LATCH; i++) begin : g_latch
			localparam logic [3:0] CODE = latch_code(i / NUM_COM,
				i % NUM_COM);
			assign lcd_mask[i] = CODE != CODE_CMOS && CODE != CODE_OD;
			// Loads proceed regardless of blanking
			always_ff @(posedge REF_CLK or posedge RST) begin
				if (RST)
					latch_r[i] <= 1'b0;
				else if (strobe[pla_stb(i)])
					latch_r[i] <= seg_bus[pla_bus(i)]; // see (R10) (R2)
			end
			// Unlit while blanked or stopped; DC latches never show here
			always_ff @(posedge REF_CLK or posedge RST) begin
				if (RST)
					SEG_PATTERN[i] <= 1'b0;
				else
					SEG_PATTERN[i] <= latch_r[i] & lcd_mask[i] &
						~blank & ~CORE_STOP;       // see (R19) (R3)
			end
			a_pin_code: assert property (@(posedge REF_CLK) // see (R11)
				CODE <= 4'h5 || CODE == CODE_OD)
				else $error("illegal pin configuration code");
		end

		// DC pins follow their first latch, blind to stop and blanking
		for (i = 0; i < NUM_SEG; i++) begin : g_dc
			localparam logic [3:0] PC = latch_code(i, 0);
			always_ff @(posedge REF_CLK or posedge RST) begin
				if (RST) begin
					DC_OUT[i]  <= 1'b0;
					DC_OE_N[i] <= 1'b1;
				end else begin
					DC_OUT[i]  <= (PC == CODE_CMOS || PC == CODE_OD) &
						latch_r[i*NUM_COM];
					// Open drain only pulls up, released for a zero
					DC_OE_N[i] <= (PC == CODE_CMOS) ? 1'b0 :
						(PC == CODE_OD) ? ~latch_r[i*NUM_COM] : 1'b1;
				end
			end
		end
	endgenerate

	// Ground and blank indications for the waveform stage
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			PANEL_GROUND <= 1'b0;
			PANEL_BLANK  <= 1'b0;
		end else begin
			PANEL_GROUND <= CORE_STOP;                 // see (R3)
			PANEL_BLANK  <= blank;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic                 aw_fire, w_fire, ar_fire;
	logic                 aw_hold_r, w_hold_r, aw_have, w_have;
	logic                 do_write, bvalid_nxt, rvalid_nxt;
	logic [3:0]           awaddr_r;
	logic [31:0]          wdata_r;
	logic [3:0]           wstrb_r;
	logic [3:0]           wa;
	logic [31:0]          wd;
	logic [3:0]           ws;
	logic                 w_ok, r_ok;
	logic [31:0]          rd_word;

	assign aw_fire = AXI_AWVALID & AXI_AWREADY;
	assign w_fire  = AXI_WVALID & AXI_WREADY;
	assign ar_fire = AXI_ARVALID & AXI_ARREADY;
	assign aw_have = aw_hold_r | aw_fire;
	assign w_have  = w_hold_r | w_fire;
	assign do_write = aw_have & w_have & ~AXI_BVALID;
	assign bvalid_nxt = do_write | (AXI_BVALID & ~AXI_BREADY);
	assign rvalid_nxt = ar_fire | (AXI_RVALID & ~AXI_RREADY);
	assign wa = aw_hold_r ? awaddr_r : AXI_AWADDR;
	assign wd = w_hold_r ? wdata_r : AXI_WDATA;
	assign ws = w_hold_r ? wstrb_r : AXI_WSTRB;
	assign w_ok = wa == CTRL_OFS || wa == STATUS_OFS || wa == INDEX_OFS;
	assign r_ok = AXI_ARADDR == CTRL_OFS || AXI_ARADDR == STATUS_OFS ||
		AXI_ARADDR == INDEX_OFS;
	assign rd_word =
		(AXI_ARADDR == CTRL_OFS) ? {31'h0, ctrl_blank_r} :
		(AXI_ARADDR == STATUS_OFS) ?
			{29'h0, blank, CORE_STOP, disp_off_r} :
		(AXI_ARADDR == INDEX_OFS) ? {24'h0, index_r} : 32'h0;

	// Write side: address and data in either order, one at a time
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			awaddr_r     <= 4'h0;
			wdata_r      <= 32'h0000_0000;
			wstrb_r      <= 4'h0;
			AXI_AWREADY  <= 1'b1;
			AXI_WREADY   <= 1'b1;
			AXI_BVALID   <= 1'b0;
			AXI_BRESP    <= RESP_OKAY;
			ctrl_blank_r <= CTRL_BLANK_RST;
		end else begin
			aw_hold_r   <= aw_have & ~do_write;
			w_hold_r    <= w_have & ~do_write;
			if (aw_fire)
				awaddr_r <= AXI_AWADDR;
			if (w_fire) begin
				wdata_r <= AXI_WDATA;
				wstrb_r <= AXI_WSTRB;
			end
			AXI_AWREADY <= ~(aw_have & ~do_write) & ~bvalid_nxt;
			AXI_WREADY  <= ~(w_have & ~do_write) & ~bvalid_nxt;
			AXI_BVALID  <= bvalid_nxt;
			if (do_write) begin
				AXI_BRESP <= w_ok ? RESP_OKAY : RESP_SLVERR;
				// Status and index words are read-only
				if (wa == CTRL_OFS && ws[0])
					ctrl_blank_r <= wd[CTRL_BLANK_BIT];
			end
		end
	end

	// Read side: one word answered the cycle after the address
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			AXI_ARREADY <= 1'b1;
			AXI_RVALID  <= 1'b0;
			AXI_RDATA   <= 32'h0000_0000;
			AXI_RRESP   <= RESP_OKAY;
		end else begin
			AXI_ARREADY <= ~rvalid_nxt;
			AXI_RVALID  <= rvalid_nxt;
			if (ar_fire) begin
				AXI_RDATA <= rd_word;
				AXI_RRESP <= r_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	a_blank_flag: assert property ( // see (R1)
		INSTR_VALID && INSTR_OP == OP_SET_FLAG2 &&
		FLAG_OPERAND == BLANK_FLAG |=> disp_off_r ##1 PANEL_BLANK)
		else $error("set flag did not blank the display");

	a_latch_kept: assert property ( // see (R1)
		flag_op |=> latch_r == $past(latch_r))
		else $error("flag instruction changed latch contents");

	a_blank_unlit: assert property ( // see (R19)
		blank && !INSTR_VALID |=> (SEG_PATTERN & lcd_mask) == '0)
		else $error("blanked display shows a lit segment");

	a_stop_ground: assert property ( // see (R3)
		CORE_STOP |=> PANEL_GROUND && (SEG_PATTERN & lcd_mask) == '0)
		else $error("stop state left panel outputs driven");

	a_decode_load: assert property ( // see (R4) (R2)
		INSTR_VALID && INSTR_OP == OP_DECODED &&
		LATCH_ADDR == pla_stb(0) |=> latch_r[0] == $past(dec_bus[0]))
		else $error("decoded load did not reach its latch");

	a_zero_blank: assert property ( // see (R5)
		INSTR_OP == OP_BLANKING && src_nib == ZERO_NIB |-> seg_bus == '0)
		else $error("leading zero not suppressed");

	a_direct_map: assert property ( // see (R6) (R17)
		INSTR_OP == OP_DIRECT |-> seg_bus[3:0] == src_nib &&
		seg_bus[7:4] == ACCUMULATOR)
		else $error("direct pattern mapping wrong");

	a_table_map: assert property ( // see (R7) (R18)
		INSTR_OP == OP_TABLE |-> seg_bus == TROM_DATA &&
		TROM_ADDR == index_r)
		else $error("table pattern mapping wrong");

	a_one_strobe: assert property ( // see (R9)
		load |-> $onehot(strobe) && strobe[LATCH_ADDR])
		else $error("strobe decode not one-hot");

	a_wreg_base: assert property ( // see (R12) (R8)
		!INSTR_INDEXED |-> src_addr == 7'(WREG_OPERAND + WREG_BASE))
		else $error("working register address wrong");

	a_index_high: assert property ( // see (R13)
		INSTR_VALID && INSTR_OP == OP_INDEX_HIGH |=>
		index_r[7:4] == $past(data_nib) &&
		index_r[3:0] == $past(index_r[3:0]))
		else $error("index high load wrong");

	a_seven_f: assert property ( // see (R16) (R15)
		src_nib == 4'h7 |-> dec_bus[5] == SEVEN_F_ON &&
		dec_bus[4:0] == 5'h07)
		else $error("digit seven decode wrong");

endmodule

`default_nettype wire

// file: lsl_pkg.sv
// Constants, opcodes and mask tables of the segment latch loader.
// Assumes one clock domain and a single-cycle instruction interface.
`default_nettype none

package lsl_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int NUM_SEG   = 12;
	localparam int NUM_COM   = 5;
	localparam int NUM_LATCH = NUM_SEG * NUM_COM;
	localparam int NUM_STB   = 16;
	localparam int MEM_DEPTH = 128;

	// ----------------------------------------------------------------
	// Addressing and operand values
	// ----------------------------------------------------------------
	localparam logic [6:0] WREG_BASE  = 7'h70;
	localparam logic [3:0] BLANK_FLAG = 4'h4;
	localparam logic [3:0] ZERO_NIB   = 4'h0;
	localparam logic [7:0] INDEX_RST  = 8'h00;
	localparam logic [7:0] BUS_ZERO   = 8'h00;

	// ----------------------------------------------------------------
	// Pin configuration codes
	// ----------------------------------------------------------------
	localparam logic [3:0] CODE_CMOS = 4'h0;
	localparam logic [3:0] CODE_OD   = 4'h9;
	localparam logic [11:0] DC_CMOS_MASK = 12'h000;
	localparam logic [11:0] DC_OD_MASK   = 12'h000;

	// ----------------------------------------------------------------
	// Register bus map
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] INDEX_OFS  = 4'h8;
	localparam int CTRL_BLANK_BIT   = 0;
	localparam int STAT_OFF_BIT     = 0;
	localparam int STAT_STOP_BIT    = 1;
	localparam int STAT_BLANK_BIT   = 2;
	localparam logic CTRL_BLANK_RST = 1'b0;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Instructions handed over by the execution unit
	typedef enum logic [3:0] {
		OP_NONE    = 4'h0,
		OP_DECODED = 4'h1,
		OP_BLANKING = 4'h2,
		OP_DIRECT  = 4'h3,
		OP_TABLE   = 4'h4,
		OP_SET_FLAG2 = 4'h5,
		OP_RESET_FLAG2 = 4'h6,
		OP_INDEX_HIGH = 4'h7,
		OP_INDEX_LOW = 4'h8
	} lsl_op_t;

	// Seven-segment decoder, bit 0 is bus line A, bit 7 line H
	function automatic logic [7:0] seg7_decode(input logic [3:0] n,
		input logic f7);
		case (n)
			4'h0: seg7_decode = 8'hBF;
			4'h1: seg7_decode = 8'h86;
			4'h2: seg7_decode = 8'hDB;
			4'h3: seg7_decode = 8'hCF;
			4'h4: seg7_decode = 8'hE6;
			4'h5: seg7_decode = 8'hED;
			4'h6: seg7_decode = 8'hFD;
			4'h7: seg7_decode = f7 ? 8'hA7 : 8'h87;
			4'h8: seg7_decode = 8'hFF;
			4'h9: seg7_decode = 8'hEF;
			default: seg7_decode = BUS_ZERO;
		endcase
	endfunction

	// Segment PLA mask: strobe and bus line feeding latch i
	function automatic logic [3:0] pla_stb(input int i);
		pla_stb = 4'(i / 4);
	endfunction

	function automatic logic [2:0] pla_bus(input int i);
		pla_bus = 3'(i % 8);
	endfunction

	// Configuration code of latch c of pin p: 1..5 panel, 0 or 9 DC
	function automatic logic [3:0] latch_code(input int p, input int c);
		if (DC_CMOS_MASK[p])
			latch_code = CODE_CMOS;
		else if (DC_OD_MASK[p])
			latch_code = CODE_OD;
		else
			latch_code = 4'(c + 1);
	endfunction

endpackage

`default_nettype wire

// file: lsl_trom_model.sv
// Table ROM stand-in facing the loader's table port.
// Assumes a combinational read, answering in the cycle it is addressed.
`default_nettype none

module lsl_trom_model (
	// ROM port
	input  wire logic [7:0] addr,
	output logic      [7:0] data
);
	timeunit 1ns;
	timeprecision 1ps;

	// Nibbles swapped and upper inverted, so every address reads unique
	assign data = {addr[3:0], ~addr[7:4]};
endmodule

`default_nettype wire

// file: lsl_latch_loader_test.sv
// Self-checking bench of the segment latch loader.
// Assumes the table ROM model and the loader package are compiled first.
`default_nettype none

module lsl_latch_loader_test import lsl_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals and expectations
	// ----------------------------------------------------------------
	logic        clk, rst, iv, ix, stp, we, gnd, blk;
	lsl_op_t     op;
	logic [3:0]  la, wr, fl, ac, wd, awa, ara, wst;
	logic [6:0]  da, wa;
	logic [7:0]  ta, td;
	logic [59:0] seg, exp_seg;
	logic [11:0] dco, dcoe;
	logic        awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
	logic [31:0] wdt, rdt, d;
	logic [1:0]  brs, rrs, r;
	int          err_total, n_tests;
	// Digit patterns, bit 0 is bus line A; digit 7 with line F off
	logic [7:0]  dec_tab [16] = '{8'hBF, 8'h86, 8'hDB, 8'hCF, 8'hE6,
		8'hED, 8'hFD, 8'h87, 8'hFF, 8'hEF, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};

	lsl_latch_loader u_dut (
		.REF_CLK(clk), .RST(rst), .INSTR_VALID(iv), .INSTR_OP(op),
		.INSTR_INDEXED(ix), .LATCH_ADDR(la), .WREG_OPERAND(wr),
		.FLAG_OPERAND(fl), .DATA_ADDR(da), .ACCUMULATOR(ac),
		.CORE_STOP(stp), .MEM_WE(we), .MEM_WADDR(wa), .MEM_WDATA(wd),
		.TROM_ADDR(ta), .TROM_DATA(td), .SEG_PATTERN(seg),
		.PANEL_GROUND(gnd), .PANEL_BLANK(blk), .DC_OUT(dco),
		.DC_OE_N(dcoe), .AXI_AWADDR(awa), .AXI_AWVALID(awv),
		.AXI_AWREADY(awr), .AXI_WDATA(wdt), .AXI_WSTRB(wst),
		.AXI_WVALID(wv), .AXI_WREADY(wrd), .AXI_BRESP(brs),
		.AXI_BVALID(bv), .AXI_BREADY(br), .AXI_ARADDR(ara),
		.AXI_ARVALID(arv), .AXI_ARREADY(arr), .AXI_RDATA(rdt),
		.AXI_RRESP(rrs), .AXI_RVALID(rv), .AXI_RREADY(rr)
	);

	lsl_trom_model u_rom (
		.addr(ta),
		.data(td)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk_seg(logic [59:0] got, logic [59:0] want);
		n_tests++;
		if (got !== want) begin
			err_total++;
			$display("wrong value t=%0t got %h exp %h", $time, got, want);
		end
	endtask

	task automatic chk_val(logic [31:0] got, logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			err_total++;
			$display("wrong value t=%0t got %h exp %h", $time, got, want);
		end
	endtask

	// Latch i takes strobe i/4 and bus line i%8
	task automatic load(logic [3:0] s, logic [7:0] b);
		for (int i = 0; i < 60; i++)
			if (i / 4 == s) exp_seg[i] = b[i % 8];
	endtask

	// Index loads read memory 10h + operand
	task automatic ins(lsl_op_t o, logic x, logic [3:0] l, logic [3:0] w,
		logic [3:0] a);
		@(posedge clk);
		iv <= 1'b1;
		op <= o;
		{ix, la, wr, fl, da, ac} <= {x, l, w, w, 3'h1, w, a};
		@(posedge clk);
		iv <= 1'b0;
	endtask

	task automatic mem(logic [6:0] a, logic [3:0] v);
		@(posedge clk);
		{we, wa, wd} <= {1'b1, a, v};
		@(posedge clk);
		we <= 1'b0;
	endtask

	// Registered outputs are looked at just after the edge has landed
	task automatic settle;
		@(posedge clk);
		#1;
	endtask

	task automatic axi_wr(logic [3:0] a, logic [31:0] v);
		@(posedge clk);
		{awa, wdt, awv, wv, br} <= {a, v, 3'b111};
		forever begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
			if (bv) begin
				r = brs;
				br <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axi_rd(logic [3:0] a);
		@(posedge clk);
		{ara, arv, rr} <= {a, 2'b11};
		forever begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
			if (rv) begin
				d = rdt;
				r = rrs;
				rr <= 1'b0;
				break;
			end
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		settle;
		chk_seg(seg, '0);
		chk_val(32'({gnd, blk, ta}), 32'h0000_0000);
		// All pins are panel pins, so DC outputs stay released and low
		chk_val(32'({dcoe, dco}), 32'h00FF_F000);
	endtask

	// Every nibble decoded then blanked, strobe F must load nothing
	task automatic t_decode;
		for (int v = 0; v < 16; v++) begin
			mem(7'h73, 4'(v));
			ins(OP_DECODED, 1'b0, 4'(v), 4'h3, 4'h0);
			load(4'(v), dec_tab[v]);
			settle;
			chk_seg(seg, exp_seg);
			ins(OP_BLANKING, 1'b0, 4'(v), 4'h3, 4'h0);
			load(4'(v), v == 0 ? 8'h00 : dec_tab[v]);
			settle;
			chk_seg(seg, exp_seg);
		end
	endtask

	task automatic t_direct;
		for (int v = 0; v < 16; v++) begin
			mem(7'h7F, 4'(v));
			ins(OP_DIRECT, 1'b0, 4'(v), 4'hF, 4'(~v));
			load(4'(v), {4'(~v), 4'(v)});
			settle;
			chk_seg(seg, exp_seg);
		end
		// Loaded latches must not leak onto the DC pins
		chk_val(32'({dcoe, dco}), 32'h00FF_F000);
	endtask

	task automatic t_index;
		mem(7'h10, 4'h2);
		mem(7'h11, 4'hA);
		ins(OP_INDEX_HIGH, 1'b0, 4'h0, 4'h0, 4'h0);
		ins(OP_INDEX_LOW, 1'b0, 4'h0, 4'h1, 4'h0);
		settle;
		chk_val(32'(ta), 32'h0000_002A);
		mem(7'h2A, 4'h6);
		ins(OP_DECODED, 1'b1, 4'h2, 4'h0, 4'h0);
		load(4'h2, dec_tab[6]);
		mem(7'h2A, 4'h0);
		ins(OP_BLANKING, 1'b1, 4'h5, 4'h0, 4'h0);
		load(4'h5, 8'h00);
		ins(OP_DIRECT, 1'b1, 4'h6, 4'h0, 4'h9);
		load(4'h6, 8'h90);
		ins(OP_TABLE, 1'b0, 4'h7, 4'h0, 4'h0);
		load(4'h7, 8'hAD);
		settle;
		chk_seg(seg, exp_seg);
	endtask

	task automatic t_blank;
		mem(7'h73, 4'h8);
		ins(OP_SET_FLAG2, 1'b0, 4'h0, 4'h3, 4'h0);
		settle;
		chk_val(32'(blk), 32'h0000_0000);
		ins(OP_SET_FLAG2, 1'b0, 4'h0, 4'h4, 4'h0);
		settle;
		chk_val(32'(blk), 32'h0000_0001);
		chk_seg(seg, '0);
		ins(OP_DECODED, 1'b0, 4'h1, 4'h3, 4'h0);
		load(4'h1, 8'hFF);
		settle;
		chk_seg(seg, '0);
		ins(OP_RESET_FLAG2, 1'b0, 4'h0, 4'h4, 4'h0);
		settle;
		chk_seg(seg, exp_seg);
	endtask

	task automatic t_stop;
		@(posedge clk);
		stp <= 1'b1;
		repeat (2) settle;
		chk_val(32'(gnd), 32'h0000_0001);
		chk_seg(seg, '0);
		@(posedge clk);
		stp <= 1'b0;
		repeat (2) settle;
		chk_seg(seg, exp_seg);
	endtask

	task automatic t_regs;
		axi_rd(4'h0);
		chk_val(d, 32'h0000_0000);
		axi_wr(4'h0, 32'h0000_0001);
		chk_val(32'(r), 32'(RESP_OKAY));
		repeat (2) settle;
		chk_seg(seg, '0);
		axi_rd(4'h4);
		chk_val(d, 32'h0000_0004);
		axi_rd(4'h8);
		chk_val(d, 32'h0000_002A);
		axi_rd(4'hC);
		chk_val(32'(r), 32'(RESP_SLVERR));
		axi_wr(4'hC, 32'h0000_0001);
		chk_val(32'(r), 32'(RESP_SLVERR));
		axi_wr(4'h0, 32'h0000_0000);
		chk_val(32'(r), 32'(RESP_OKAY));
		repeat (2) settle;
		chk_seg(seg, exp_seg);
	endtask

	// Mid-run reset clears latches and index but keeps data memory,
	// so the digit written earlier at 73h must still decode
	task automatic t_rst_mid;
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		exp_seg = '0;
		settle;
		chk_seg(seg, '0);
		chk_val(32'({dcoe, dco, ta}), 32'hFFF0_0000);
		ins(OP_DECODED, 1'b0, 4'h0, 4'h3, 4'h0);
		load(4'h0, dec_tab[8]);
		settle;
		chk_seg(seg, exp_seg);
	endtask

	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		{rst, wst} = {1'b1, 4'hF};
		op = OP_NONE;
		{iv, ix, stp, we, awv, wv, br, arv, rr} = '0;
		{la, wr, fl, ac, da, wa, wd, awa, ara, wdt} = '0;
		{err_total, n_tests, exp_seg} = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_decode;
		t_direct;
		t_index;
		t_blank;
		t_stop;
		t_regs;
		t_rst_mid;
		print_verdict;
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#100us;
		err_total++;
		print_verdict;
	end
endmodule

`default_nettype wire
